/* File: common/isvm_pkg.sv */
// Shared constants and types for the interrupt source to vector mapping
package isvm_pkg;

  // Range of vectors handled by this block
  localparam int VEC_LO = 42;
  localparam int VEC_HI = 116;

  // Reserved vectors with no source
  localparam int VEC_RSV_A = 42;
  localparam int VEC_RSV_B = 45;
  localparam int VEC_RSV_C = 49;

  // Single-source vectors, except 46 which ORs the four wakeup events
  localparam int VEC_SEM_CORE1 = 43;
  localparam int VEC_SEM_CORE0 = 44;
  localparam int VEC_WAKEUP = 46;
  localparam int VEC_LOW_VOLT = 47;
  localparam int VEC_I2C = 48;

  // Clock monitor vectors, not sourced here
  localparam int VEC_CLK_LOSS = 50;
  localparam int VEC_LOCK_LOSS = 51;

  // External interrupt group
  localparam int VEC_EXT_OVR = 52;
  localparam int VEC_EXT_FIRST = 53;
  localparam int EXT_SINGLE_N = 4;
  localparam int VEC_EXT_UPPER = 57;
  localparam int EXT_N = 16;

  // Timer channel group
  localparam int VEC_TMR_FIRST = 58;
  localparam int TMR_N = 24;

  // Converter FIFO group
  localparam int VEC_CNV_OVR = 82;
  localparam int VEC_CNV_FIRST = 83;
  localparam int CNV_N = 6;
  localparam int CNV_STRIDE = 5;
  localparam int CNV_NONCOH_POS = 0;
  localparam int CNV_PAUSE_POS = 1;
  localparam int CNV_EOQ_POS = 2;
  localparam int CNV_FILL_POS = 3;
  localparam int CNV_DRAIN_POS = 4;

  // Serial unit group
  localparam int VEC_SER_FIRST = 113;
  localparam int SER_N = 4;
  localparam int SCI_EVT_W = 9;
  localparam int LIN_EVT_W = 9;

  // Serial status event positions
  localparam int SCI_TX_EMPTY_POS = 0;
  localparam int SCI_TX_DONE_POS = 1;
  localparam int SCI_RX_FULL_POS = 2;
  localparam int SCI_IDLE_POS = 3;
  localparam int SCI_OVERRUN_POS = 4;
  localparam int SCI_NOISE_POS = 5;
  localparam int SCI_FRAMING_POS = 6;
  localparam int SCI_PARITY_POS = 7;
  localparam int SCI_BIT_ERR_POS = 8;

  // LIN event positions
  localparam int LIN_RX_RDY_POS = 0;
  localparam int LIN_TX_RDY_POS = 1;
  localparam int LIN_WAKE_POS = 2;
  localparam int LIN_TIMEOUT_POS = 3;
  localparam int LIN_PHY_ERR_POS = 4;
  localparam int LIN_CRC_ERR_POS = 5;
  localparam int LIN_CHK_ERR_POS = 6;
  localparam int LIN_FRAME_POS = 7;
  localparam int LIN_RX_OVF_POS = 8;

  // Handler address calculation
  localparam int VEC_NUM_W = 8;
  localparam int BASE_W = 20;
  localparam int OFF_W = 12;
  localparam int ADDR_W = 32;
  localparam int VEC_ADDR_STEP = 4;
  localparam logic [11:0] SW_VEC_OFFSET = 12'h040;

  // Reset values
  localparam logic [VEC_HI:VEC_LO] VEC_REQ_RST = '0;
  localparam logic [ADDR_W-1:0] ADDR_RST = 32'h0000_0000;

  // Vector request vector type
  typedef logic [VEC_HI:VEC_LO] isvm_vec_t;

endpackage

/* File: common/isvm_serial_if.sv */
`timescale 1ns/1ps
// Event bundle of one serial unit and its combined request
interface isvm_serial_if;
  import isvm_pkg::*;
  logic [SCI_EVT_W-1:0] sci_evt; // Serial status events
  logic [LIN_EVT_W-1:0] lin_evt; // LIN status events
  logic comb_req; // Combined request back to the mapper

  // Mapper side
  modport src (output sci_evt, output lin_evt, input comb_req);
  // Combiner side
  modport comb (input sci_evt, input lin_evt, output comb_req);
endinterface

/* File: hdl/isvm_serial_comb.sv */
`timescale 1ns/1ps
// Combines every serial and LIN event of one unit into one request
module isvm_serial_comb (
  isvm_serial_if.comb bus
);
  import isvm_pkg::*;

  // Any serial status event
  logic sci_any;
  // Any LIN event
  logic lin_any;

  // Serial status requests ORed together
  assign sci_any = |bus.sci_evt;
  // LIN requests join the same vector
  assign lin_any = |bus.lin_evt;
  // One shared request for the unit
  assign bus.comb_req = sci_any | lin_any;

endmodule

/* File: hdl/isvm_top.sv */
`timescale 1ns/1ps
// Functional notes
// - Semaphore free per core drives 43, 44
// - Vector 46 ORs the four wakeup unit events (pin, periodic, RTC match, RTC rollover)
// - Vector 47 follows low-voltage inhibit event
// - Vector 48 follows the I2C event flag
// - Vector 52 ORs all sixteen overrun bits
// - External flags 0 to 3 drive 53-56
// - Vector 57 ORs external flags 4 to 15
// - Timer channels 0-23 drive vectors 58-81
// - Vector 82 ORs all converter error flags
// - Five vectors per converter FIFO from 83
// - Serial units A-D combine onto 113-116
// - LIN events join their unit's request
// - Hardware mode handler at base plus vector*4
// - Shared vectors are the OR of sources
module isvm_top (
  // System clock, 20 MHz
  input wire logic sys_clk,
  // Asynchronous reset, active low
  input wire logic rst_n,
  // Semaphore freed for core 1 and core 0 requester
  input wire logic sem_free_core1,
  input wire logic sem_free_core0,
  // Wakeup unit events
  input wire logic pin_wakeup,
  input wire logic periodic_wakeup,
  input wire logic rtc_match,
  input wire logic rtc_rollover,
  // Supply monitor event
  input wire logic low_voltage_inhibit,
  // I2C single interrupt flag
  input wire logic i2c_event_flag,
  // External interrupt overrun bits
  input wire logic [isvm_pkg::EXT_N-1:0] ext_irq_overrun_bits,
  // External interrupt status flags
  input wire logic [isvm_pkg::EXT_N-1:0] ext_irq_status_reg,
  // Timer channel flags
  input wire logic [isvm_pkg::TMR_N-1:0] timer_chan_flags,
  // Converter FIFO error flags, one bit per FIFO
  input wire logic [isvm_pkg::CNV_N-1:0] trigger_overrun_flag,
  input wire logic [isvm_pkg::CNV_N-1:0] result_fifo_overflow_flag,
  input wire logic [isvm_pkg::CNV_N-1:0] cmd_fifo_underflow_flag,
  // Converter FIFO per-queue flags, one bit per FIFO
  input wire logic [isvm_pkg::CNV_N-1:0] cmd_noncoherency_flag,
  input wire logic [isvm_pkg::CNV_N-1:0] cmd_pause_flag,
  input wire logic [isvm_pkg::CNV_N-1:0] queue_end_flag,
  input wire logic [isvm_pkg::CNV_N-1:0] cmd_fifo_fill_flag,
  input wire logic [isvm_pkg::CNV_N-1:0] result_fifo_drain_flag,
  // Serial status events per unit
  input wire logic [isvm_pkg::SER_N-1:0][isvm_pkg::SCI_EVT_W-1:0] serial_status_evt,
  // LIN events per unit
  input wire logic [isvm_pkg::SER_N-1:0][isvm_pkg::LIN_EVT_W-1:0] lin_status_evt,
  // Handler lookup: vector mode, base and vector to look up
  input wire logic hw_vector_mode,
  input wire logic [isvm_pkg::BASE_W-1:0] vector_base,
  input wire logic [isvm_pkg::VEC_NUM_W-1:0] lookup_vector,
  // Registered vector requests toward the core
  output logic [isvm_pkg::VEC_HI:isvm_pkg::VEC_LO] vec_req_r,
  // Any vector of this range requested
  output logic any_req_r,
  // Handler address for the looked-up vector
  output logic [isvm_pkg::ADDR_W-1:0] handler_addr_r,
  // Looked-up vector is in range and not reserved in hardware mode, always set in software mode
  output logic lookup_valid_r
);
  import isvm_pkg::*;

  // Next value of the vector request register
  isvm_vec_t vec_req_nxt;
  // Next value of the any-request flag
  logic any_req_nxt;
  // Next handler address
  logic [ADDR_W-1:0] handler_addr_nxt;
  // Next lookup validity
  logic lookup_valid_nxt;
  // Combined wakeup request
  logic wake_any;
  // Combined converter error request
  logic cnv_err_any;
  // Lookup vector offset in bytes
  logic [OFF_W-1:0] hw_offset;
  // Lookup vector inside this block's range
  logic lookup_in_range;
  // Lookup vector is one of the reserved ones
  logic lookup_reserved;

  // Reserved vectors have no source
  assign vec_req_nxt[VEC_RSV_A] = 1'b0;
  assign vec_req_nxt[VEC_RSV_B] = 1'b0;
  assign vec_req_nxt[VEC_RSV_C] = 1'b0;

  // Clock monitor vectors are sourced outside this block
  assign vec_req_nxt[VEC_CLK_LOSS] = 1'b0;
  assign vec_req_nxt[VEC_LOCK_LOSS] = 1'b0;

  // Semaphore release per requesting core
  assign vec_req_nxt[VEC_SEM_CORE1] = sem_free_core1;
  assign vec_req_nxt[VEC_SEM_CORE0] = sem_free_core0;

  // Wakeup unit events merged into one request
  assign wake_any = pin_wakeup | periodic_wakeup | rtc_match | rtc_rollover;
  assign vec_req_nxt[VEC_WAKEUP] = wake_any;

  // Supply monitor event
  assign vec_req_nxt[VEC_LOW_VOLT] = low_voltage_inhibit;

  // I2C flag already merges its four causes inside the unit
  assign vec_req_nxt[VEC_I2C] = i2c_event_flag;

  // Any external interrupt overrun
  assign vec_req_nxt[VEC_EXT_OVR] = |ext_irq_overrun_bits;

  // External flags 0 to 3, one vector each
  generate
    for (genvar g = 0; g < EXT_SINGLE_N; g++) begin : g_ext
      assign vec_req_nxt[VEC_EXT_FIRST + g] = ext_irq_status_reg[g];
    end
  endgenerate

  // Upper external flags share one vector
  assign vec_req_nxt[VEC_EXT_UPPER] = |ext_irq_status_reg[EXT_N-1:EXT_SINGLE_N];

  // Timer channels, one vector each in channel order
  generate
    for (genvar g = 0; g < TMR_N; g++) begin : g_tmr
      assign vec_req_nxt[VEC_TMR_FIRST + g] = timer_chan_flags[g];
    end
  endgenerate

  // Error flags of every converter FIFO on one vector
  assign cnv_err_any = (|trigger_overrun_flag) | (|result_fifo_overflow_flag)
                     | (|cmd_fifo_underflow_flag);
  assign vec_req_nxt[VEC_CNV_OVR] = cnv_err_any;

  // Five vectors per converter FIFO, fixed order within each group
  generate
    for (genvar g = 0; g < CNV_N; g++) begin : g_cnv
      // Non-coherency first
      assign vec_req_nxt[VEC_CNV_FIRST + CNV_STRIDE*g + CNV_NONCOH_POS] =
        cmd_noncoherency_flag[g];
      // Then pause
      assign vec_req_nxt[VEC_CNV_FIRST + CNV_STRIDE*g + CNV_PAUSE_POS] =
        cmd_pause_flag[g];
      // Then end of queue
      assign vec_req_nxt[VEC_CNV_FIRST + CNV_STRIDE*g + CNV_EOQ_POS] =
        queue_end_flag[g];
      // Then command FIFO fill
      assign vec_req_nxt[VEC_CNV_FIRST + CNV_STRIDE*g + CNV_FILL_POS] =
        cmd_fifo_fill_flag[g];
      // Result FIFO drain last
      assign vec_req_nxt[VEC_CNV_FIRST + CNV_STRIDE*g + CNV_DRAIN_POS] =
        result_fifo_drain_flag[g];
    end
  endgenerate

  // Serial units: each combiner merges its serial and LIN events
  generate
    for (genvar g = 0; g < SER_N; g++) begin : g_ser
      // Event bundle for this unit
      isvm_serial_if ser_bus ();
      // Serial status events into the bundle
      assign ser_bus.sci_evt = serial_status_evt[g];
      // LIN events join the same bundle
      assign ser_bus.lin_evt = lin_status_evt[g];
      // Per-unit combiner
      isvm_serial_comb u_comb (
        .bus (ser_bus)
      );
      // Unit request onto its vector in unit order
      assign vec_req_nxt[VEC_SER_FIRST + g] = ser_bus.comb_req;
    end
  endgenerate

  // Summary of all requests in range
  assign any_req_nxt = |vec_req_nxt;

  // Byte offset of the looked-up vector from the base
  assign hw_offset = OFF_W'(lookup_vector * VEC_ADDR_STEP);

  // Range check for the looked-up vector
  assign lookup_in_range = (lookup_vector >= VEC_NUM_W'(VEC_LO))
                        && (lookup_vector <= VEC_NUM_W'(VEC_HI));

  // Reserved vectors have no handler
  assign lookup_reserved = (lookup_vector == VEC_NUM_W'(VEC_RSV_A))
                        || (lookup_vector == VEC_NUM_W'(VEC_RSV_B))
                        || (lookup_vector == VEC_NUM_W'(VEC_RSV_C));

  // Handler address: per-vector in hardware mode, one entry otherwise
  always_comb begin
    if (hw_vector_mode) begin
      // Base plus vector number times four bytes
      handler_addr_nxt = {vector_base, hw_offset};
      lookup_valid_nxt = lookup_in_range && !lookup_reserved;
    end else begin
      // Software mode uses the shared external input entry
      handler_addr_nxt = {vector_base, SW_VEC_OFFSET};
      lookup_valid_nxt = 1'b1;
    end
  end

  // Vector request register, one cycle behind the flags
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      vec_req_r <= VEC_REQ_RST;
    end else begin
      vec_req_r <= vec_req_nxt;
    end
  end

  // Any-request summary register, aligned with the vector register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      any_req_r <= 1'b0;
    end else begin
      any_req_r <= any_req_nxt;
    end
  end

  // Handler address register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      handler_addr_r <= ADDR_RST;
    end else begin
      handler_addr_r <= handler_addr_nxt;
    end
  end

  // Lookup validity register, aligned with the address
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lookup_valid_r <= 1'b0;
    end else begin
      lookup_valid_r <= lookup_valid_nxt;
    end
  end

endmodule

/* File: bench/isvm_props_properties.sv */
`timescale 1ns/1ps
// Checks source to vector timing and the hardware mode handler address at the top ports
module isvm_props (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic sem_free_core1,
  input wire logic sem_free_core0,
  input wire logic pin_wakeup,
  input wire logic periodic_wakeup,
  input wire logic rtc_match,
  input wire logic rtc_rollover,
  input wire logic low_voltage_inhibit,
  input wire logic i2c_event_flag,
  input wire logic [isvm_pkg::EXT_N-1:0] ext_irq_overrun_bits,
  input wire logic [isvm_pkg::EXT_N-1:0] ext_irq_status_reg,
  input wire logic [isvm_pkg::TMR_N-1:0] timer_chan_flags,
  input wire logic hw_vector_mode,
  input wire logic [isvm_pkg::BASE_W-1:0] vector_base,
  input wire logic [isvm_pkg::VEC_NUM_W-1:0] lookup_vector,
  input wire logic [isvm_pkg::VEC_HI:isvm_pkg::VEC_LO] vec_req_r,
  input wire logic [isvm_pkg::ADDR_W-1:0] handler_addr_r,
  input wire logic any_req_r
);
  import isvm_pkg::*;
  // Slices named so the sampled-value functions see plain signals
  wire [3:0] ext_lo = ext_irq_status_reg[3:0];
  wire ext_hi_any = |ext_irq_status_reg[15:4];
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_sem_free_map: assert property (
    $past(rst_n) |-> vec_req_r[44:43] == {$past(sem_free_core0), $past(sem_free_core1)})
    else $error("Semaphore vectors do not follow their sources");
  a_wakeup_or_map: assert property (
    $past(rst_n) |-> vec_req_r[46] == $past(pin_wakeup | periodic_wakeup | rtc_match | rtc_rollover))
    else $error("Wakeup vector is not the OR of its four events");
  a_hw_handler_addr: assert property (
    $past(rst_n) && $past(hw_vector_mode) |->
      handler_addr_r == {$past(vector_base), 2'h0, $past(lookup_vector), 2'h0})
    else $error("Hardware mode handler address is not base plus vector times four");
  a_low_volt_map: assert property (
    $past(rst_n) |-> vec_req_r[47] == $past(low_voltage_inhibit))
    else $error("Low voltage vector does not follow its source");
  a_i2c_rise_seen: assert property (
    $rose(i2c_event_flag) |=> vec_req_r[48] && any_req_r)
    else $error("I2C vector missed a rising flag");
  a_ext_ovr_or: assert property (
    $past(rst_n) |-> vec_req_r[52] == (|$past(ext_irq_overrun_bits)))
    else $error("Overrun vector is not the OR of the overrun bits");
  a_ext_single_map: assert property (
    $past(rst_n) |-> vec_req_r[56:53] == $past(ext_lo))
    else $error("External flags 0 to 3 mismatched");
  a_ext_upper_or: assert property (
    $past(rst_n) |-> vec_req_r[57] == $past(ext_hi_any))
    else $error("Upper external vector is not the OR of flags 4 to 15");
  a_timer_map: assert property (
    $past(rst_n) |-> vec_req_r[81:58] == $past(timer_chan_flags))
    else $error("Timer vectors mismatched");
  a_reserved_quiet: assert property (
    !vec_req_r[42] && !vec_req_r[45] && !vec_req_r[49])
    else $error("Reserved vector asserted");
endmodule

bind isvm_top isvm_props u_props (.*);

/* File: bench/isvm_core_model.sv */
`timescale 1ns/1ps
// Core side: remembers every vector it has been offered since clear
module isvm_core_model (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clr,
  input wire isvm_pkg::isvm_vec_t vec_req,
  output isvm_pkg::isvm_vec_t seen_r
);
  import isvm_pkg::*;
  // Sticky record of offered requests
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      seen_r <= '0;
    end else if (clr) begin
      seen_r <= '0;
    end else begin
      seen_r <= seen_r | vec_req;
    end
  end
endmodule

/* File: bench/isvm_top_tb_top.sv */
`timescale 1ns/1ps
// Drives every source of the vector map and checks the requests
module isvm_top_tb_top;
  import isvm_pkg::*;
  logic sys_clk, rst_n, sem_free_core1, sem_free_core0, pin_wakeup, periodic_wakeup;
  logic rtc_match, rtc_rollover, low_voltage_inhibit, i2c_event_flag, hw_vector_mode;
  logic [EXT_N-1:0] ext_irq_overrun_bits, ext_irq_status_reg;
  logic [TMR_N-1:0] timer_chan_flags;
  logic [CNV_N-1:0] trigger_overrun_flag, result_fifo_overflow_flag, cmd_fifo_underflow_flag;
  logic [CNV_N-1:0] cmd_noncoherency_flag, cmd_pause_flag, queue_end_flag;
  logic [CNV_N-1:0] cmd_fifo_fill_flag, result_fifo_drain_flag;
  logic [SER_N-1:0][SCI_EVT_W-1:0] serial_status_evt;
  logic [SER_N-1:0][LIN_EVT_W-1:0] lin_status_evt;
  logic [BASE_W-1:0] vector_base;
  logic [VEC_NUM_W-1:0] lookup_vector;
  logic [ADDR_W-1:0] handler_addr_r;
  logic any_req_r, lookup_valid_r, core_clr;
  isvm_vec_t vec_req_r, seen_r;
  int bad_count, samples_checked;

  isvm_top u_dut (.*);
  isvm_core_model u_core (.sys_clk(sys_clk), .rst_n(rst_n), .clr(core_clr),
    .vec_req(vec_req_r), .seen_r(seen_r));

  // Free running 50 ns clock
  always #25 sys_clk = ~sys_clk;

  // Sets every flag source to one level
  task automatic fill_all(logic v);
    {sem_free_core1, sem_free_core0, pin_wakeup, periodic_wakeup} = {4{v}};
    {rtc_match, rtc_rollover, low_voltage_inhibit, i2c_event_flag} = {4{v}};
    {ext_irq_overrun_bits, ext_irq_status_reg, timer_chan_flags} = {(2*EXT_N+TMR_N){v}};
    {trigger_overrun_flag, result_fifo_overflow_flag, cmd_fifo_underflow_flag} = {18{v}};
    {cmd_noncoherency_flag, cmd_pause_flag, queue_end_flag} = {18{v}};
    {cmd_fifo_fill_flag, result_fifo_drain_flag} = {12{v}};
    serial_status_evt = {(SER_N*SCI_EVT_W){v}};
    lin_status_evt = {(SER_N*LIN_EVT_W){v}};
  endtask

  // One vector bit set
  function automatic isvm_vec_t one_hot(int v);
    isvm_vec_t e;
    e = '0;
    e[v] = 1'b1;
    return e;
  endfunction

  // Every sourced vector set, reserved and clock monitor ones clear
  function automatic isvm_vec_t sourced_mask();
    isvm_vec_t e;
    e = '1;
    {e[42], e[45], e[49], e[50], e[51]} = 5'h00;
    return e;
  endfunction

  // Lets one edge take the inputs, then compares the requests
  task automatic step_check(string what, isvm_vec_t exp);
    @(posedge sys_clk);
    #5;
    samples_checked++;
    if (vec_req_r !== exp || any_req_r !== (|exp)) begin
      bad_count++;
      $display("Error %s expected %h seen %h any %b", what, exp, vec_req_r, any_req_r);
    end
  endtask

  // Single sources, one per cycle
  task automatic t_misc();
    int vmap[8] = '{43, 44, 46, 46, 46, 46, 47, 48};
    for (int i = 0; i < 8; i++) begin
      fill_all(1'b0);
      {sem_free_core1, sem_free_core0, pin_wakeup, periodic_wakeup, rtc_match,
       rtc_rollover, low_voltage_inhibit, i2c_event_flag} = 8'h80 >> i;
      step_check("misc vector", one_hot(vmap[i]));
    end
  endtask

  // External overrun and status flags, each bit alone
  task automatic t_ext();
    for (int i = 0; i < EXT_N; i++) begin
      fill_all(1'b0);
      ext_irq_overrun_bits[i] = 1'b1;
      step_check("ext overrun", one_hot(52));
      fill_all(1'b0);
      ext_irq_status_reg[i] = 1'b1;
      step_check("ext flag", one_hot(i < 4 ? 53 + i : 57));
    end
  endtask

  // Timer channels back to back
  task automatic t_timer();
    for (int i = 0; i < TMR_N; i++) begin
      fill_all(1'b0);
      timer_chan_flags[i] = 1'b1;
      step_check("timer", one_hot(58 + i));
    end
  endtask

  // Every converter flag of every FIFO
  task automatic t_cnv();
    for (int n = 0; n < CNV_N; n++) begin
      for (int k = 0; k < 8; k++) begin
        fill_all(1'b0);
        case (k)
          0: trigger_overrun_flag[n] = 1'b1;
          1: result_fifo_overflow_flag[n] = 1'b1;
          2: cmd_fifo_underflow_flag[n] = 1'b1;
          3: cmd_noncoherency_flag[n] = 1'b1;
          4: cmd_pause_flag[n] = 1'b1;
          5: queue_end_flag[n] = 1'b1;
          6: cmd_fifo_fill_flag[n] = 1'b1;
          default: result_fifo_drain_flag[n] = 1'b1;
        endcase
        step_check("converter", one_hot(k < 3 ? 82 : 80 + 5 * n + k));
      end
    end
  endtask

  // Every serial and LIN event of every unit
  task automatic t_serial();
    for (int u = 0; u < SER_N; u++) begin
      for (int b = 0; b < 18; b++) begin
        fill_all(1'b0);
        if (b < 9) begin
          serial_status_evt[u][b] = 1'b1;
        end else begin
          lin_status_evt[u][b-9] = 1'b1;
        end
        step_check("serial", one_hot(113 + u));
      end
    end
  endtask

  // Mid-run reset with every source high, then release
  task automatic t_reset();
    logic ok;
    fill_all(1'b1);
    rst_n = 1'b0;
    @(posedge sys_clk);
    #5;
    samples_checked++;
    ok = (vec_req_r === VEC_REQ_RST) && ({any_req_r, lookup_valid_r} === 2'h0);
    if (!ok || handler_addr_r !== ADDR_RST) begin
      bad_count++;
      $display("Error reset outputs expected %h seen %h", VEC_REQ_RST, vec_req_r);
    end
    fill_all(1'b0);
    rst_n = 1'b1;
    step_check("reset release", '0);
  endtask

  // All sources at once, then all released
  task automatic t_all();
    fill_all(1'b1);
    step_check("all sources", sourced_mask());
    fill_all(1'b0);
    step_check("all released", '0);
  endtask

  // Handler lookup in hardware and software mode
  task automatic t_lookup();
    int vecs[7] = '{42, 43, 49, 113, 116, 117, 43};
    logic [ADDR_W-1:0] exp;
    logic val;
    vector_base = 20'hA5C3E;
    for (int i = 0; i < 7; i++) begin
      hw_vector_mode = (i < 6);
      lookup_vector = vecs[i][7:0];
      exp = hw_vector_mode ? {vector_base, 2'h0, lookup_vector, 2'h0} : {vector_base, 12'h040};
      val = !hw_vector_mode || (vecs[i] inside {[43:44], [46:48], [50:116]});
      @(posedge sys_clk);
      #5;
      samples_checked++;
      if (handler_addr_r !== exp || lookup_valid_r !== val) begin
        bad_count++;
        $display("Error handler expected %h %b seen %h %b", exp, val, handler_addr_r,
          lookup_valid_r);
      end
    end
  endtask

  // Prints the counts and the verdict, then stops
  task automatic print_verdict();
    $display("Checked %0d samples, %0d mismatches", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    {sys_clk, rst_n, hw_vector_mode, core_clr} = 4'h1;
    {vector_base, lookup_vector} = '0;
    fill_all(1'b0);
    repeat (4) @(posedge sys_clk);
    #5;
    rst_n = 1'b1;
    core_clr = 1'b0;
    t_misc();
    t_ext();
    t_timer();
    t_cnv();
    t_serial();
    t_reset();
    t_all();
    t_lookup();
    samples_checked++;
    if (seen_r !== sourced_mask()) begin
      bad_count++;
      $display("Error core seen expected %h seen %h", sourced_mask(), seen_r);
    end
    print_verdict();
  end

  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    repeat (2000) @(posedge sys_clk);
    bad_count++;
    $display("Error watchdog expected finish seen hang");
    print_verdict();
  end
endmodule
